/* motor_ctrl_pkg.sv */
// shared constants for the pulse motor mode and command controller
package motor_ctrl_pkg;
  localparam int NUM_CH = 4;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_STATUS  = 12'h004;
  localparam logic [11:0] OFS_RXCHAR  = 12'h008;
  localparam logic [11:0] OFS_CMD     = 12'h00C;
  localparam logic [11:0] OFS_NOTICE  = 12'h010;
  localparam logic [11:0] OFS_SPEEDS  = 12'h014;
  localparam logic [11:0] OFS_JOGCNT  = 12'h018;
  localparam logic [11:0] OFS_STOPCFG = 12'h01C;
  localparam int CH_OFS_BASE = 'h020;

  // control register fields
  localparam int CTRL_HOST_BIT  = 0;
  localparam int CTRL_HBOX_BIT  = 1;
  localparam int CTRL_HPDIR_BIT = 2;
  localparam int CTRL_MODE_LSB  = 4;

  // command register fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_CH_LSB  = 4;
  localparam int CMD_ACC_BIT = 8;
  localparam int CMD_DIR_BIT = 9;

  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  localparam logic [7:0] SPEED_CODE_MAX = 8'hFE;

  localparam int CLK_HZ          = 100_000_000;
  localparam int JOG_HOLD_MS     = 500;
  localparam int JOG_HOLD_CYCLES = CLK_HZ / 1000 * JOG_HOLD_MS;
  localparam int GPIB_WAIT_US    = 1000;
  localparam int GPIB_WAIT_CYCLES = CLK_HZ / 1_000_000 * GPIB_WAIT_US;

  typedef enum logic [1:0] {
    offset_move_mode,
    target_position_mode,
    home_search_mode,
    continuous_mode
  } drive_mode_e;

  typedef enum logic [3:0] {
    op_none,
    panel_control_cmd,
    host_control_cmd,
    arm_stop_notice_cmd,
    clear_stop_notice_cmd,
    query_stop_notice_cmd,
    read_status_cmd,
    move_cmd,
    stop_cmd
  } cmd_op_e;
endpackage

/* motor_ctrl.sv */
// pulse motor mode, command and stop notice controller
//
// Contract
// RULE1: host_mode bit selects panel or host mode; toggle button or command switches it.
// RULE2: speed button picks high, middle or low speed preset in panel mode.
// RULE3: host move without ramp flag runs at constant rate.
// RULE4: abrupt stop mode on stop source ends pulses immediately, no ramp.
// RULE5: panel controls act only on enabled channels; code's stop button ends output on every channel, enabled or not.
// RULE6: offset move start drives all enabled channels with their counts.
// RULE7: target mode start sets direction from sign of target minus position.
// RULE8: home search runs in configured direction until home switch.
// RULE9: limit switch or stop button ends pulse output; code honours the stop button in panel mode only.
// RULE10: continuous mode drives only while jog lever pushed after start.
// RULE11: jog emits count; held past 0.5 s or done, runs till release.
// RULE12: jog lever works in all four panel drive modes.
// RULE13: hold-off released while driving, restored after stop.
// RULE14: hand-box controls all channels when always, else enabled only; code decodes only hbox_ch[1], so it reaches channels 0 and 2 alone.
// RULE15: read-out commands answered in both modes.
// RULE16: malformed or unexecutable commands are discarded without reply.
// RULE17: characters gather until CR then LF; commands run in order.
// RULE18: talker handshake held until reply ready, at most 1 ms.
// RULE19: serial framing fixed at 8 data, 1 stop, no parity, no flow control.
// RULE20: mode-switch commands accepted only when all channels stopped.
// RULE21: armed channel stop raises service request and notice bit; read clears.
// RULE22: arm clears on request raise; clear disarms; query replies 1 or 0.
// RULE23: speed presets are 8-bit codes 0 to 254.
`timescale 1ns/1ps
module motor_ctrl
  import motor_ctrl_pkg::*;
#(
  parameter int JOG_HOLD = JOG_HOLD_CYCLES,
  parameter int GPIB_WAIT = GPIB_WAIT_CYCLES
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  input  wire logic               host_toggle_btn,
  input  wire logic               start_btn,
  input  wire logic               stop_btn,
  input  wire logic               speed_btn,
  input  wire logic [NUM_CH-1:0]  enable_btn,
  input  wire logic               jog_cw,
  input  wire logic               jog_ccw,
  input  wire logic               hbox_jog_cw,
  input  wire logic               hbox_jog_ccw,
  input  wire logic [1:0]         hbox_ch,
  input  wire logic [NUM_CH-1:0]  limit_sw,
  input  wire logic [NUM_CH-1:0]  home_sw,
  input  wire logic [NUM_CH-1:0]  pulse_done,
  input  wire logic [NUM_CH-1:0]  hold_off_cfg,
  output logic                    host_mode,
  output logic [1:0]              speed_sel,
  output logic [NUM_CH-1:0]       ch_enable,
  output logic [NUM_CH-1:0]       drive,
  output logic [NUM_CH-1:0]       drive_dir,
  output logic [NUM_CH-1:0]       ramp_en,
  output logic [NUM_CH-1:0]       hold_off,
  output logic                    srq,
  output logic                    talker_hold
);
  localparam int SYNC_W = 9 + 3 * NUM_CH + 5;

  initial begin
    if (NUM_CH != 4) $error("four channels only");
    if (JOG_HOLD < 1 || GPIB_WAIT < 1) $error("counts must be positive");
  end

  // three-stage sync of panel inputs; first stage read only by second
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] s1_r, s2_r, s3_r, pin_r;
  assign pin_raw = {host_toggle_btn, start_btn, stop_btn, speed_btn, jog_cw, jog_ccw,
                    hbox_jog_cw, hbox_jog_ccw, hbox_ch[1], enable_btn, limit_sw, home_sw,
                    1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      pin_r <= '0;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < SYNC_W; i++) begin
        if (s2_r[i] == s3_r[i]) pin_r[i] <= s3_r[i];
      end
    end
  end
  logic [SYNC_W-1:0] pin_d_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pin_d_r <= '0;
    else pin_d_r <= pin_r;
  end
  logic [SYNC_W-1:0] rise;
  assign rise = pin_r & ~pin_d_r;
  logic toggle_p, start_p, stop_lv, speed_p, jcw, jccw, hcw, hccw;
  logic [NUM_CH-1:0] en_p, lim, home;
  assign toggle_p = rise[SYNC_W-1];
  assign start_p  = rise[SYNC_W-2];
  assign stop_lv  = pin_r[SYNC_W-3];
  assign speed_p  = rise[SYNC_W-4];
  assign jcw      = pin_r[SYNC_W-5];
  assign jccw     = pin_r[SYNC_W-6];
  assign hcw      = pin_r[SYNC_W-7];
  assign hccw     = pin_r[SYNC_W-8];
  assign en_p     = rise[5+2*NUM_CH +: NUM_CH];
  assign lim      = pin_r[5+NUM_CH +: NUM_CH];
  assign home     = pin_r[5 +: NUM_CH];

  // registers
  logic              hbox_always_r, hp_dir_r;
  drive_mode_e       mode_r;
  logic [7:0]        spd_h_r, spd_m_r, spd_l_r;
  logic [15:0]       jog_count_r;
  logic [NUM_CH-1:0] abrupt_r;
  logic [15:0]       ch_param_r [NUM_CH];
  logic [NUM_CH-1:0] arm_r, notice_r;
  logic [7:0]        cmd_buf_r;
  logic              cr_seen_r, cmd_ready_r;
  logic [31:0]       reply_r;
  logic              reply_valid_r;

  logic wr_acc, rd_acc;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  // decoded host command
  cmd_op_e op;
  logic [1:0] cmd_ch;
  logic all_stopped;
  assign op = cmd_op_e'(pwdata[CMD_OP_LSB +: 4]);
  assign cmd_ch = pwdata[CMD_CH_LSB +: 2];
  assign all_stopped = (drive == '0);
  logic cmd_wr;
  // RULE17: command acted on only once framed and in arrival order
  assign cmd_wr = wr_acc && (paddr == OFS_CMD) && cmd_ready_r;

  // RULE19: 8-bit characters
  // RULE17: CR then LF completes the frame; other chars are partial
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_buf_r <= '0;
      cr_seen_r <= 1'b0;
      cmd_ready_r <= 1'b0;
    end else if (wr_acc && paddr == OFS_RXCHAR) begin
      cmd_buf_r <= pwdata[7:0];
      cr_seen_r <= (pwdata[7:0] == CHAR_CR);
      if (cr_seen_r && pwdata[7:0] == CHAR_LF) cmd_ready_r <= 1'b1;
    end else if (wr_acc && paddr == OFS_CMD) begin
      cmd_ready_r <= 1'b0;
    end
  end

  // RULE1: panel toggle or host command switches mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) host_mode <= 1'b0;
    // RULE20: mode commands need every channel stopped
    else if (cmd_wr && all_stopped && op == panel_control_cmd) host_mode <= 1'b0;
    else if (cmd_wr && all_stopped && op == host_control_cmd) host_mode <= 1'b1;
    else if (toggle_p) host_mode <= ~host_mode;
  end

  // RULE2: speed button cycles high, middle, low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) speed_sel <= 2'd0;
    else if (speed_p && !host_mode) speed_sel <= (speed_sel == 2'd2) ? 2'd0 : speed_sel + 2'd1;
  end

  // RULE5: enable buttons toggle per-channel enable in panel mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ch_enable <= '0;
    else if (!host_mode) ch_enable <= ch_enable ^ en_p;
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hbox_always_r <= 1'b0;
      hp_dir_r <= 1'b0;
      mode_r <= offset_move_mode;
      spd_h_r <= '0;
      spd_m_r <= '0;
      spd_l_r <= '0;
      jog_count_r <= '0;
      abrupt_r <= '0;
      for (int i = 0; i < NUM_CH; i++) ch_param_r[i] <= '0;
    end else if (wr_acc) begin
      case (paddr)
        OFS_CTRL: begin
          hbox_always_r <= pwdata[CTRL_HBOX_BIT];
          hp_dir_r <= pwdata[CTRL_HPDIR_BIT];
          mode_r <= drive_mode_e'(pwdata[CTRL_MODE_LSB +: 2]);
        end
        OFS_SPEEDS: begin
          // RULE23: codes above 254 are refused
          if (pwdata[23:16] <= SPEED_CODE_MAX) spd_h_r <= pwdata[23:16];
          if (pwdata[15:8] <= SPEED_CODE_MAX) spd_m_r <= pwdata[15:8];
          if (pwdata[7:0] <= SPEED_CODE_MAX) spd_l_r <= pwdata[7:0];
        end
        OFS_JOGCNT: jog_count_r <= pwdata[15:0];
        OFS_STOPCFG: abrupt_r <= pwdata[NUM_CH-1:0];
        default: begin
          for (int i = 0; i < NUM_CH; i++) begin
            if (paddr == 12'(CH_OFS_BASE + 4 * i)) ch_param_r[i] <= pwdata[15:0];
          end
        end
      endcase
    end
  end

  // jog source: front lever or hand-box
  logic [NUM_CH-1:0] hbox_sel;
  logic jog_any;
  assign hbox_sel = NUM_CH'(1) << {pin_r[5+3*NUM_CH], 1'b0};
  assign jog_any = jcw | jccw | hcw | hccw;

  logic [NUM_CH-1:0] drive_nxt;
  logic [31:0] jog_timer_r;
  logic [15:0] jog_left_r;
  logic scan_armed_r;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      logic panel_ok, hbox_ok, jog_here, start_here, stop_here;
      logic jog_run_r;
      assign panel_ok = !host_mode && ch_enable[g];
      // RULE14: hand-box reach depends on its setting
      assign hbox_ok = !host_mode && hbox_sel[g] && (hbox_always_r || ch_enable[g]);
      // RULE12: jog honoured in every drive mode
      assign jog_here = (panel_ok && (jcw || jccw)) || (hbox_ok && (hcw || hccw));
      assign start_here = panel_ok && start_p && mode_r != continuous_mode;
      // RULE9: limit, stop button in panel mode, pulse_done or home switch in home search mode ends output
      assign stop_here = lim[g] || (stop_lv && !host_mode) || pulse_done[g] ||
                         (mode_r == home_search_mode && home[g]);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          drive[g] <= 1'b0;
          drive_dir[g] <= 1'b0;
          ramp_en[g] <= 1'b0;
          hold_off[g] <= 1'b0;
          jog_run_r <= 1'b0;
        end else begin
          if (stop_here && drive[g]) begin
            drive[g] <= 1'b0;
          end else if (start_here) begin
            // RULE6: offset move starts every enabled channel together
            drive[g] <= 1'b1;
            ramp_en[g] <= 1'b1;
            jog_run_r <= 1'b0;
            // RULE7: direction from sign of target minus position
            if (mode_r == target_position_mode) drive_dir[g] <= ch_param_r[g][15];
            // RULE8: home search uses configured direction
            else if (mode_r == home_search_mode) drive_dir[g] <= hp_dir_r;
            else drive_dir[g] <= ch_param_r[g][15];
          end else if (jog_here && !drive[g] &&
                       (mode_r != continuous_mode || scan_armed_r)) begin
            // RULE10: continuous mode waits for lever after start
            drive[g] <= 1'b1;
            ramp_en[g] <= 1'b1;
            drive_dir[g] <= jccw || hccw;
            jog_run_r <= 1'b1;
          end else if (cmd_wr && op == move_cmd && cmd_ch == 2'(g) && host_mode) begin
            drive[g] <= 1'b1;
            // RULE3: no ramp flag means constant rate
            ramp_en[g] <= pwdata[CMD_ACC_BIT];
            drive_dir[g] <= pwdata[CMD_DIR_BIT];
            jog_run_r <= 1'b0;
          end else if (cmd_wr && op == stop_cmd && cmd_ch == 2'(g)) begin
            drive[g] <= 1'b0;
            // RULE11: lever release ends a lever run
          end else if (drive[g] && !jog_here && jog_left_r == '0 && jog_run_r) begin
            drive[g] <= 1'b0;
          end
          // RULE4: abrupt stop drops the ramp
          if (stop_here && abrupt_r[g]) ramp_en[g] <= 1'b0;
          // RULE13: hold-off released only while driving
          hold_off[g] <= hold_off_cfg[g] && !drive[g];
        end
      end
    end
  endgenerate
  assign drive_nxt = drive;

  // RULE11: jog count then continue while held past 0.5 s
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jog_timer_r <= '0;
      jog_left_r <= '0;
      scan_armed_r <= 1'b0;
    end else begin
      if (start_p && !host_mode && mode_r == continuous_mode) scan_armed_r <= 1'b1;
      else if (stop_lv || mode_r != continuous_mode) scan_armed_r <= 1'b0;
      if (!jog_any) begin
        jog_timer_r <= '0;
        jog_left_r <= '0;
      end else if (jog_timer_r == '0) begin
        jog_timer_r <= 32'd1;
        jog_left_r <= jog_count_r;
      end else if (jog_timer_r < 32'(JOG_HOLD)) begin
        jog_timer_r <= jog_timer_r + 32'd1;
        if (jog_left_r != '0) jog_left_r <= jog_left_r - 16'd1;
      end
    end
  end

  // RULE21: armed channel stop sets notice and service request
  logic [NUM_CH-1:0] stop_ev, drive_d_r;
  logic notice_rd;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) drive_d_r <= '0;
    else drive_d_r <= drive_nxt;
  end
  assign stop_ev = drive_d_r & ~drive;
  assign notice_rd = rd_acc && paddr == OFS_NOTICE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_r <= '0;
      notice_r <= '0;
      srq <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        // RULE22: arm self-clears once request raised, beating a same-cycle arm command; notice set beats read clear
        if (stop_ev[i] && arm_r[i]) begin
          notice_r[i] <= 1'b1;
          arm_r[i] <= 1'b0;
        end else begin
          if (notice_rd) notice_r[i] <= 1'b0;
          if (cmd_wr && cmd_ch == 2'(i) && op == arm_stop_notice_cmd) arm_r[i] <= 1'b1;
          if (cmd_wr && cmd_ch == 2'(i) && op == clear_stop_notice_cmd) arm_r[i] <= 1'b0;
        end
      end
      srq <= |(stop_ev & arm_r) || (|notice_r && !notice_rd);
    end
  end

  // RULE15: read-out replies prepared in either mode
  // RULE16: unknown or refused commands leave no reply
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reply_r <= '0;
      reply_valid_r <= 1'b0;
    end else if (cmd_wr && op == query_stop_notice_cmd) begin
      reply_r <= {31'd0, arm_r[cmd_ch]};
      reply_valid_r <= 1'b1;
    end else if (cmd_wr && op == read_status_cmd) begin
      reply_r <= {23'd0, host_mode, drive, ch_enable};
      reply_valid_r <= 1'b1;
    end else if (rd_acc && paddr == OFS_STATUS) begin
      reply_valid_r <= 1'b0;
    end
  end

  // RULE18: talker held until reply ready, bounded by timeout
  logic [31:0] wait_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      talker_hold <= 1'b0;
      wait_r <= '0;
    end else if (cmd_wr && (op == query_stop_notice_cmd || op == read_status_cmd)) begin
      talker_hold <= 1'b1;
      wait_r <= '0;
    end else if (talker_hold) begin
      wait_r <= wait_r + 32'd1;
      if (reply_valid_r || wait_r >= 32'(GPIB_WAIT - 1)) talker_hold <= 1'b0;
    end
  end

  // APB slave: zero wait, unmapped read returns zero with error
  logic mapped;
  assign mapped = (paddr <= OFS_STOPCFG) || (paddr >= 12'(CH_OFS_BASE) &&
                  paddr < 12'(CH_OFS_BASE + 4 * NUM_CH) && paddr[1:0] == 2'b00);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      // error judged in setup so it stands through the access cycle
      pslverr <= psel && !penable && !mapped;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= '0;
    else if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_CTRL: prdata <= {26'd0, mode_r, 1'b0, hp_dir_r, hbox_always_r, host_mode};
        OFS_STATUS: prdata <= reply_r;
        OFS_RXCHAR: prdata <= {22'd0, cmd_ready_r, cr_seen_r, cmd_buf_r};
        OFS_NOTICE: prdata <= {24'd0, arm_r, notice_r};
        OFS_SPEEDS: prdata <= {6'd0, speed_sel, spd_h_r, spd_m_r, spd_l_r};
        OFS_JOGCNT: prdata <= {16'd0, jog_count_r};
        OFS_STOPCFG: prdata <= {16'd0, hold_off, drive_dir, drive, abrupt_r};
        default: begin
          prdata <= '0;
          for (int i = 0; i < NUM_CH; i++) begin
            if (paddr == 12'(CH_OFS_BASE + 4 * i)) prdata <= {16'd0, ch_param_r[i]};
          end
        end
      endcase
    end
  end
endmodule

/* motor_ctrl_monitor.sv */
// concurrent checks on the motor controller ports
`timescale 1ns/1ps
module motor_ctrl_monitor
  import motor_ctrl_pkg::*;
#(
  parameter int GPIB_WAIT = GPIB_WAIT_CYCLES
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [1:0]        speed_sel,
  input wire logic [NUM_CH-1:0] drive,
  input wire logic [NUM_CH-1:0] limit_sw,
  input wire logic [NUM_CH-1:0] hold_off_cfg,
  input wire logic [NUM_CH-1:0] hold_off,
  input wire logic              srq,
  input wire logic              talker_hold
);
  int unsigned hold_cnt_r;
  logic        rd_notice;
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign rd_notice = psel && penable && !pwrite && (paddr == OFS_NOTICE);
  // length of the current handshake hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_r <= 0;
    end else if (talker_hold) begin
      hold_cnt_r <= hold_cnt_r + 1;
    end else begin
      hold_cnt_r <= 0;
    end
  end
  a_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  a_err_access_only: assert property (pslverr |-> psel && penable)
    else $error("error response outside access phase");
  a_speed_range: assert property (speed_sel != 2'h3)
    else $error("speed preset select out of range");
  a_talker_bound: assert property (hold_cnt_r <= GPIB_WAIT + 1)
    else $error("handshake held too long");
  a_srq_cause: assert property ($rose(srq) |-> ($past(drive, 1) | $past(drive, 2) |
    $past(drive, 3) | $past(drive, 4)) != 0)
    else $error("service request without a stop");
  a_srq_clear: assert property ($fell(srq) |->
    $past(rd_notice, 1) || $past(rd_notice, 2) || $past(rd_notice, 3))
    else $error("service request dropped without notice read");
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    a_hold_released: assert property ($rose(drive[i]) |-> ##[0:1] !hold_off[i])
      else $error("hold-off kept while driving");
    a_hold_restored: assert property ($fell(drive[i]) && hold_off_cfg[i] |->
      ##[0:2] hold_off[i])
      else $error("hold-off not restored after stop");
    a_limit_stops: assert property ($rose(limit_sw[i]) |-> ##[1:8] !drive[i])
      else $error("limit did not end pulse output");
  end
endmodule

bind motor_ctrl motor_ctrl_monitor #(.GPIB_WAIT(GPIB_WAIT)) mon_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .speed_sel(speed_sel),
  .drive(drive), .limit_sw(limit_sw), .hold_off_cfg(hold_off_cfg), .hold_off(hold_off),
  .srq(srq), .talker_hold(talker_hold));

/* motor_sim.sv */
// far-side motor drive model reporting count completion
`timescale 1ns/1ps
module motor_sim
  import motor_ctrl_pkg::*;
#(
  parameter int DONE_DLY = 60
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [NUM_CH-1:0] drive,
  output logic      [NUM_CH-1:0] pulse_done
);
  int unsigned run_cnt_r [NUM_CH];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_done <= '0;
      for (int i = 0; i < NUM_CH; i++) run_cnt_r[i] <= 0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (!drive[i]) begin
          run_cnt_r[i] <= 0;
          pulse_done[i] <= 1'b0;
        end else if (run_cnt_r[i] == DONE_DLY) begin
          pulse_done[i] <= 1'b1;
        end else begin
          run_cnt_r[i] <= run_cnt_r[i] + 1;
        end
      end
    end
  end
endmodule

/* tb.sv */
// self-checking bench for the motor controller
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
  $display("mismatch at %0t: got %h exp %h", $time, a, e); end end
module tb;
  import motor_ctrl_pkg::*;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rexp;
    logic        eexp;
  } reg_row_s;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              host_toggle_btn, start_btn, stop_btn, speed_btn, jog_cw, jog_ccw;
  logic              hbox_jog_cw, hbox_jog_ccw, host_mode, srq, talker_hold;
  logic [1:0]        hbox_ch, speed_sel;
  logic [NUM_CH-1:0] enable_btn, limit_sw, home_sw, pulse_done, hold_off_cfg;
  logic [NUM_CH-1:0] ch_enable, drive, drive_dir, ramp_en, hold_off;
  int                miscompares, check_count, cyc;
  reg_row_s          rows [5] = '{
    '{OFS_SPEEDS, 32'h0110_2030, 32'h0010_2030, 1'b0},
    '{OFS_SPEEDS, 32'h02FF_FE00, 32'h0010_FE00, 1'b0},
    '{OFS_JOGCNT, 32'h0000_0005, 32'h0000_0005, 1'b0},
    '{OFS_STOPCFG, 32'h0000_000F, 32'h0000_000F, 1'b0},
    '{12'h100, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}};

  motor_ctrl #(.JOG_HOLD(20), .GPIB_WAIT(10)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .host_toggle_btn(host_toggle_btn), .start_btn(start_btn), .stop_btn(stop_btn),
    .speed_btn(speed_btn), .enable_btn(enable_btn), .jog_cw(jog_cw), .jog_ccw(jog_ccw),
    .hbox_jog_cw(hbox_jog_cw), .hbox_jog_ccw(hbox_jog_ccw), .hbox_ch(hbox_ch),
    .limit_sw(limit_sw), .home_sw(home_sw), .pulse_done(pulse_done),
    .hold_off_cfg(hold_off_cfg), .host_mode(host_mode), .speed_sel(speed_sel),
    .ch_enable(ch_enable), .drive(drive), .drive_dir(drive_dir), .ramp_en(ramp_en),
    .hold_off(hold_off), .srq(srq), .talker_hold(talker_hold));
  motor_sim #(.DONE_DLY(60)) sim_u (
    .pclk(pclk), .presetn(presetn), .drive(drive), .pulse_done(pulse_done));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] mk(input logic [3:0] op, input logic [1:0] ch,
                                      input logic acc, input logic dir);
    mk = {22'h0, dir, acc, 2'h0, ch, op};
  endfunction
  // delimiter pair, then the command word
  task automatic cmd(input logic [31:0] c);
    apb(1'b1, OFS_RXCHAR, {24'h0, CHAR_CR});
    apb(1'b1, OFS_RXCHAR, {24'h0, CHAR_LF});
    apb(1'b1, OFS_CMD, c);
    repeat (3) @(posedge pclk);
  endtask
  task automatic ask();
    cmd(mk(query_stop_notice_cmd, 2'h0, 1'b0, 1'b0));
    repeat (12) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h0);
  endtask
  // press and release one button, long enough for the synchronisers
  task automatic press(input int b);
    repeat (2) begin
      @(posedge pclk);
      case (b)
        0: start_btn <= ~start_btn;
        2: speed_btn <= ~speed_btn;
        3: host_toggle_btn <= ~host_toggle_btn;
        default: enable_btn[b-5] <= ~enable_btn[b-5];
      endcase
      repeat (8) @(posedge pclk);
    end
  endtask

  initial begin
    {presetn, psel, penable, pwrite, host_toggle_btn, start_btn, stop_btn} = '0;
    {speed_btn, jog_cw, jog_ccw, hbox_jog_cw, hbox_jog_ccw} = '0;
    {paddr, pwdata, hbox_ch, enable_btn, limit_sw, home_sw, hold_off_cfg} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK({host_mode, srq, talker_hold, drive, ch_enable}, 11'h0)
    foreach (rows[i]) begin
      apb(1'b1, rows[i].addr, rows[i].wdata);
      apb(1'b0, rows[i].addr, 32'h0);
      `CHK({er, rd}, {rows[i].eexp, rows[i].rexp})
    end
    `CHK(speed_sel, 2'h0)
    hold_off_cfg <= 4'h1;
    press(3);
    `CHK(host_mode, 1'b1)
    cmd(mk(panel_control_cmd, 2'h0, 1'b0, 1'b0));
    `CHK(host_mode, 1'b0)
    cmd(mk(host_control_cmd, 2'h0, 1'b0, 1'b0));
    `CHK(host_mode, 1'b1)
    apb(1'b1, OFS_CMD, mk(panel_control_cmd, 2'h0, 1'b0, 1'b0));
    repeat (3) @(posedge pclk);
    `CHK(host_mode, 1'b1)
    apb(1'b0, OFS_RXCHAR, 32'h0);
    `CHK(rd[9:0], 10'h00A)
    cmd(mk(arm_stop_notice_cmd, 2'h0, 1'b0, 1'b0));
    cmd(mk(clear_stop_notice_cmd, 2'h0, 1'b0, 1'b0));
    ask();
    `CHK(rd[0], 1'b0)
    cmd(mk(arm_stop_notice_cmd, 2'h0, 1'b0, 1'b0));
    ask();
    `CHK(rd[0], 1'b1)
    cmd(mk(move_cmd, 2'h0, 1'b0, 1'b1));
    `CHK({drive[0], drive_dir[0], ramp_en[0]}, 3'b110)
    `CHK(hold_off[0], 1'b0)
    cmd(mk(panel_control_cmd, 2'h0, 1'b0, 1'b0));
    `CHK(host_mode, 1'b1)
    for (int k = 0; k < 200 && srq !== 1'b1; k++) @(posedge pclk);
    repeat (3) @(posedge pclk);
    `CHK(srq, 1'b1)
    `CHK({drive[0], hold_off[0]}, 2'b01)
    apb(1'b0, OFS_NOTICE, 32'h0);
    `CHK(rd[7:0], 8'h01)
    repeat (3) @(posedge pclk);
    `CHK(srq, 1'b0)
    apb(1'b0, OFS_NOTICE, 32'h0);
    `CHK(rd[3:0], 4'h0)
    cmd(mk(panel_control_cmd, 2'h0, 1'b0, 1'b0));
    `CHK(host_mode, 1'b0)
    apb(1'b1, OFS_CTRL, 32'h0);
    press(6);
    `CHK(ch_enable, 4'b0010)
    press(0);
    `CHK(drive, 4'b0010)
    limit_sw <= 4'b0010;
    repeat (10) @(posedge pclk);
    `CHK(drive[1], 1'b0)
    `CHK(ramp_en[1], 1'b0)
    limit_sw <= 4'b0000;
    repeat (8) @(posedge pclk);
    jog_cw <= 1'b1;
    repeat (10) @(posedge pclk);
    `CHK(drive, 4'b0010)
    repeat (30) @(posedge pclk);
    `CHK(drive[1], 1'b1)
    jog_cw <= 1'b0;
    repeat (10) @(posedge pclk);
    `CHK(drive[1], 1'b0)
    press(2);
    `CHK(speed_sel, 2'h1)
    complete_run();
  end
endmodule
